// ---- stop_reset_pkg.sv ----
package stop_reset_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int BOOST_MIN_NS = 4060;
  localparam int BOOST_CYC = (BOOST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int BOOST_EXT_CYC = 160;
  localparam int WAIT_VEC_CYC = 8;
  localparam int WAIT_NOVEC_CYC = 2;
  localparam int SETTLE_DEF_CYC = 256;
  localparam int RST_PROC_CYC = 16;
  localparam int CNT_W = 16;

  // ****************************************
  // Reset vector and sources
  // ****************************************
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
  localparam int SRC_PIN = 0;
  localparam int SRC_WDT = 1;
  localparam int SRC_POC = 2;
  localparam int SRC_LVD = 3;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STOP = 3'b001,
    ST_SETTLE = 3'b010,
    ST_BOOST = 3'b011,
    ST_WAIT = 3'b100,
    ST_RESET = 3'b101,
    ST_RST_SETTLE = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic int_mask_flag;
    logic int_level_flag;
    logic irq_accept_enable;
    logic in_service_priority;
  } irq_view_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic vector_take;
    logic resume_next;
    logic start_at_reset_vec;
  } cpu_ctl_t;

endpackage

// ---- stop_release_and_reset_control.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Unmasked interrupt ends STOP after settling.
// - Wait 8 clocks vectored, 2 otherwise.
// - Mask, priority, enable and IN_SERVICE_PRIORITY choose outcome.
// - Reset in STOP acts as normal reset.
// - Boost at entry gates clock after release.
// - Low-speed osc keeps pre-STOP state.
// - Four reset sources merged into one.
// - Every reset starts at vector 0000H.
// - Ports float in reset, echo pin low.
// - Low pin holds reset, high releases.
// - Watchdog reset releases itself.
// - Voltage resets release when supply recovers.
// - Oscillators stopped, external clocks ignored in reset.
// - STOP contents kept while reset held.
// - Detector reset never resets the detector.
// - CAN runs in STOP, divider halted.
// - Serial ports run only on allowed clocks.
// - Watchdog reset also resets watchdog.
module stop_release_and_reset_control
  import stop_reset_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_DEF_CYC,
  parameter int PORT_W = 8
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Reset sources
  input wire logic reset_pin_n,
  input wire logic wdt_overflow,
  input wire logic poc_below,
  input wire logic lvd_below,
  // STOP control
  input wire logic stop_req,
  input wire logic osc_amp_boost,
  input wire logic ext_clk_selected,
  input wire logic low_speed_sw_run,
  input wire logic irq_req,
  input wire irq_view_t irq_view,
  // Peripheral clock selections
  input wire logic serial_on_timer_a_out,
  input wire logic clocked_serial_ext_clk,
  // CPU and clocks
  output cpu_ctl_t cpu_ctl,
  output logic [15:0] start_addr,
  output logic osc_run,
  output logic ext_clk_accept,
  output logic low_speed_osc_run,
  output logic osc_settle_count_status,
  output logic in_stop,
  output logic sys_reset_out,
  output logic wdt_reset,
  output logic lvd_reset_block,
  // Peripheral gating in STOP
  output logic can_run,
  output logic muldiv_run,
  output logic async_serial_a_run,
  output logic async_serial_b_run,
  output logic clocked_serial_port_run,
  // Port pins
  output logic [PORT_W-1:0] port_oe_n,
  output logic reset_echo_port_pin
);

  // Settle count must fit the shared down-counter
  if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << CNT_W) || PORT_W < 1)
  begin : g_bad_param
    $error("stop_release_and_reset_control: bad parameter");
  end

  // ****************************************
  // Reset merge
  // ****************************************
  logic [3:0] rst_src;
  logic rst_any;
  assign rst_src = {lvd_below, poc_below, wdt_overflow, ~reset_pin_n};
  assign rst_any = |rst_src;

  localparam logic [CNT_W-1:0] SETTLE_LD = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] RSTPROC_LD = CNT_W'(RST_PROC_CYC - 1);
  localparam logic [CNT_W-1:0] BOOST_LD = CNT_W'(BOOST_CYC - 1);
  localparam logic [CNT_W-1:0] BOOSTX_LD = CNT_W'(BOOST_EXT_CYC - 1);
  localparam logic [CNT_W-1:0] WVEC_LD = CNT_W'(WAIT_VEC_CYC - 1);
  localparam logic [CNT_W-1:0] WNOV_LD = CNT_W'(WAIT_NOVEC_CYC - 1);

  seq_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic boost_r;
  logic vec_r;
  logic wake;
  logic vec_dec;

  // Table decision: mask holds STOP, level/enable/IN_SERVICE_PRIORITY pick servicing
  assign wake = irq_req && !irq_view.int_mask_flag;
  assign vec_dec = irq_view.int_level_flag ?
                   (irq_view.irq_accept_enable && irq_view.in_service_priority) :
                   irq_view.irq_accept_enable;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_RESET;
      cnt_r <= RSTPROC_LD;
      boost_r <= 1'b0;
      vec_r <= 1'b0;
    end
    else if (rst_any)
    begin
      // Reset wins over every STOP phase
      state_r <= ST_RESET;
      cnt_r <= RSTPROC_LD;
      vec_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_RUN:
        begin
          if (stop_req)
          begin
            state_r <= ST_STOP;
            boost_r <= osc_amp_boost;
          end
        end
        ST_STOP:
        begin
          if (wake)
          begin
            state_r <= ST_SETTLE;
            cnt_r <= SETTLE_LD;
            vec_r <= vec_dec;
          end
        end
        ST_SETTLE:
        begin
          if (cnt_r == '0)
          begin
            if (boost_r)
            begin
              state_r <= ST_BOOST;
              cnt_r <= ext_clk_selected ? BOOSTX_LD : BOOST_LD;
            end
            else
            begin
              state_r <= ST_WAIT;
              cnt_r <= vec_r ? WVEC_LD : WNOV_LD;
            end
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        ST_BOOST:
        begin
          if (cnt_r == '0)
          begin
            state_r <= ST_WAIT;
            cnt_r <= vec_r ? WVEC_LD : WNOV_LD;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        ST_WAIT:
        begin
          if (cnt_r == '0)
            state_r <= ST_RUN;
          else
            cnt_r <= cnt_r - 1'b1;
        end
        ST_RESET:
        begin
          // Sources released: automatic for watchdog and voltage
          state_r <= ST_RST_SETTLE;
          cnt_r <= RSTPROC_LD;
        end
        ST_RST_SETTLE:
        begin
          if (cnt_r == '0)
            state_r <= ST_RUN;
          else
            cnt_r <= cnt_r - 1'b1;
        end
        default:
          state_r <= ST_RESET;
      endcase
    end
  end

  // ****************************************
  // CPU side outputs
  // ****************************************
  logic leave_wait;
  logic leave_rst;
  assign leave_wait = (state_r == ST_WAIT) && (cnt_r == '0) && !rst_any;
  assign leave_rst = (state_r == ST_RST_SETTLE) && (cnt_r == '0) && !rst_any;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cpu_ctl <= '0;
      start_addr <= RESET_VEC_ADDR;
      in_stop <= 1'b0;
      sys_reset_out <= 1'b1;
    end
    else
    begin
      cpu_ctl.cpu_clk_en <= (state_r == ST_RUN && !stop_req && !rst_any) ||
                            leave_wait || leave_rst;
      cpu_ctl.vector_take <= leave_wait && vec_r;
      cpu_ctl.resume_next <= leave_wait && !vec_r;
      cpu_ctl.start_at_reset_vec <= leave_rst;
      start_addr <= RESET_VEC_ADDR;
      in_stop <= !rst_any && (state_r == ST_STOP || (state_r == ST_RUN && stop_req));
      sys_reset_out <= rst_any || (state_r == ST_RESET) ||
                       (state_r == ST_RST_SETTLE && !leave_rst);
    end
  end

  // ****************************************
  // Oscillators and detectors
  // ****************************************
  logic rst_phase;
  assign rst_phase = rst_any || state_r == ST_RESET;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      osc_run <= 1'b0;
      ext_clk_accept <= 1'b0;
      low_speed_osc_run <= 1'b0;
      osc_settle_count_status <= 1'b0;
      wdt_reset <= 1'b1;
      lvd_reset_block <= 1'b0;
    end
    else
    begin
      osc_run <= !rst_phase;
      ext_clk_accept <= !rst_phase;
      // Frozen through STOP unless a reset arrives: otherwise it only stops there if software stopped it first
      if (state_r != ST_STOP || rst_phase)
        low_speed_osc_run <= !rst_phase && low_speed_sw_run;
      osc_settle_count_status <= (state_r == ST_RUN) || (state_r == ST_BOOST) ||
                                 (state_r == ST_WAIT);
      wdt_reset <= rst_any;
      // Keeps the detector alive across its own reset
      lvd_reset_block <= lvd_below;
    end
  end

  // ****************************************
  // Peripherals and pins
  // ****************************************
  logic stopped;
  assign stopped = (state_r == ST_STOP);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      can_run <= 1'b0;
      muldiv_run <= 1'b0;
      async_serial_a_run <= 1'b0;
      async_serial_b_run <= 1'b0;
      clocked_serial_port_run <= 1'b0;
    end
    else
    begin
      can_run <= !rst_phase;
      muldiv_run <= !rst_phase && !stopped;
      async_serial_a_run <= !rst_phase && (!stopped || serial_on_timer_a_out);
      async_serial_b_run <= !rst_phase && (!stopped || serial_on_timer_a_out);
      clocked_serial_port_run <= !rst_phase && (!stopped || clocked_serial_ext_clk);
    end
  end

  logic float_pins;
  assign float_pins = rst_any || state_r == ST_RESET || state_r == ST_RST_SETTLE;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      port_oe_n <= '1;
      reset_echo_port_pin <= 1'b0;
    end
    else
    begin
      port_oe_n <= float_pins ? '1 : '0;
      reset_echo_port_pin <= !float_pins;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_mask_holds;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_r == ST_STOP && !rst_any && !wake) |=> state_r == ST_STOP;
  endproperty
  a_mask_holds: assert property (p_mask_holds) else $error("STOP left without cause");

  property p_reset_wins;
    @(posedge ref_clk) disable iff (sys_rst)
    rst_any |=> state_r == ST_RESET && sys_reset_out;
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("reset not taken");

  property p_wait_vec;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_r != ST_WAIT ##1 state_r == ST_WAIT && vec_r) |->
      (state_r == ST_WAIT && !rst_any)[*8] |=> state_r == ST_RUN;
  endproperty
  a_wait_vec: assert property (p_wait_vec) else $error("vectored wait length wrong");

  property p_wait_novec;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_r != ST_WAIT ##1 state_r == ST_WAIT && !vec_r && !rst_any ##1 !rst_any)
      |=> state_r == ST_RUN;
  endproperty
  a_wait_novec: assert property (p_wait_novec) else $error("plain wait length wrong");

  property p_float;
    @(posedge ref_clk) disable iff (sys_rst)
    rst_any |=> port_oe_n == '1 && !reset_echo_port_pin;
  endproperty
  a_float: assert property (p_float) else $error("pins not floated in reset");

  property p_vec_addr;
    @(posedge ref_clk) disable iff (sys_rst)
    cpu_ctl.start_at_reset_vec |-> start_addr == 16'h0000 && cpu_ctl.cpu_clk_en;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("bad reset vector");

  property p_osc_off;
    @(posedge ref_clk) disable iff (sys_rst)
    rst_any |=> !osc_run && !ext_clk_accept && !low_speed_osc_run;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator running in reset");

  property p_decide;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_r == ST_STOP && wake && !rst_any) |=>
      vec_r == $past(vec_dec) && state_r == ST_SETTLE;
  endproperty
  a_decide: assert property (p_decide) else $error("wake decision wrong");

  property p_muldiv;
    @(posedge ref_clk) disable iff (sys_rst)
    state_r == ST_STOP |=> !muldiv_run;
  endproperty
  a_muldiv: assert property (p_muldiv) else $error("divider runs in STOP");

  property p_ls_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_r == ST_STOP && !rst_any) |=> $stable(low_speed_osc_run);
  endproperty
  a_ls_hold: assert property (p_ls_hold) else $error("low-speed osc moved in STOP");

  c_wake_vec: cover property (@(posedge ref_clk) cpu_ctl.vector_take);
  c_wake_next: cover property (@(posedge ref_clk) cpu_ctl.resume_next);
  c_boost: cover property (@(posedge ref_clk) state_r == ST_BOOST);
  c_stop_reset: cover property (@(posedge ref_clk) state_r == ST_STOP ##1 state_r == ST_RESET);

endmodule
`default_nettype wire

// ---- irq_reset_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_reset_partner
  import stop_reset_pkg::*;
#(
  parameter int PIN_LOW_CYC = 1250
)
(
  // Clock and commands
  input wire logic ref_clk,
  input wire logic irq_fire,
  input wire irq_view_t view_in,
  input wire logic pin_fire,
  // Device side
  input wire cpu_ctl_t cpu_ctl,
  input wire logic sys_reset_out,
  output logic irq_req,
  output irq_view_t irq_view,
  output logic reset_pin_n
);
  logic irq_r = 1'b0;
  irq_view_t view_r = '0;
  int pin_cnt_r = 0;
  // Request stays pending until the CPU takes it or a reset wipes it
  always_ff @(posedge ref_clk)
  begin
    if (irq_fire)
    begin
      irq_r <= 1'b1;
      view_r <= view_in;
    end
    else if (sys_reset_out || cpu_ctl.vector_take || cpu_ctl.resume_next)
      irq_r <= 1'b0;
  end
  // Pin held low for the full minimum width, never shorter
  always_ff @(posedge ref_clk)
  begin
    if (pin_fire)
      pin_cnt_r <= PIN_LOW_CYC;
    else if (pin_cnt_r != 0)
      pin_cnt_r <= pin_cnt_r - 1;
  end
  assign irq_req = irq_r;
  assign irq_view = view_r;
  assign reset_pin_n = (pin_cnt_r == 0);
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
  import stop_reset_pkg::*;
  localparam int PW = 8;
  localparam int SETTLE = 4;
  logic ref_clk = 0;
  logic sys_rst = 1;
  logic stop_req = 0, boost = 0, ext_sel = 0, ls_run = 1, ser_a = 0, csi_ext = 1;
  logic wdt = 0, power_on_clear = 0, lvd = 0, irq_fire = 0, pin_fire = 0;
  irq_view_t view_in = '0;
  irq_view_t irq_view;
  cpu_ctl_t cpu_ctl;
  logic irq_req, reset_pin_n, osc_run, ext_acc, ls_osc, settle_st, in_stop, rst_out;
  logic wdt_rst, lvd_blk, can_run, md_run, sa_run, sb_run, csp_run, echo;
  logic [15:0] start_addr;
  logic [PW-1:0] oe_n;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  irq_reset_partner u_far (.ref_clk(ref_clk), .irq_fire(irq_fire), .view_in(view_in),
    .pin_fire(pin_fire), .cpu_ctl(cpu_ctl), .sys_reset_out(rst_out), .irq_req(irq_req),
    .irq_view(irq_view), .reset_pin_n(reset_pin_n));
  stop_release_and_reset_control #(.SETTLE_CYC(SETTLE), .PORT_W(PW)) u_dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .wdt_overflow(wdt), .poc_below(power_on_clear),
    .lvd_below(lvd), .stop_req(stop_req), .osc_amp_boost(boost), .ext_clk_selected(ext_sel),
    .low_speed_sw_run(ls_run), .irq_req(irq_req), .irq_view(irq_view),
    .serial_on_timer_a_out(ser_a), .clocked_serial_ext_clk(csi_ext), .cpu_ctl(cpu_ctl),
    .start_addr(start_addr), .osc_run(osc_run), .ext_clk_accept(ext_acc),
    .low_speed_osc_run(ls_osc), .osc_settle_count_status(settle_st), .in_stop(in_stop),
    .sys_reset_out(rst_out), .wdt_reset(wdt_rst), .lvd_reset_block(lvd_blk),
    .can_run(can_run), .muldiv_run(md_run), .async_serial_a_run(sa_run),
    .async_serial_b_run(sb_run), .clocked_serial_port_run(csp_run), .port_oe_n(oe_n),
    .reset_echo_port_pin(echo));

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial forever #4 ref_clk = ~ref_clk;

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic chk_rst();
    `CHK(rst_out, 1'b1)
    `CHK(oe_n, {PW{1'b1}})
    `CHK(echo, 1'b0)
    `CHK(osc_run, 1'b0)
    `CHK(ext_acc, 1'b0)
    `CHK(ls_osc, 1'b0)
    `CHK(cpu_ctl.cpu_clk_en, 1'b0)
  endtask

  task automatic boot();
    int i;
    @(posedge ref_clk);
    #1;
    `CHK(oe_n, {PW{1'b1}})
    for (i = 0; i < 100 && cpu_ctl.start_at_reset_vec !== 1'b1; i++)
      @(posedge ref_clk) #1;
    `CHK(cpu_ctl.start_at_reset_vec, 1'b1)
    `CHK(start_addr, 16'h0000)
    @(posedge ref_clk) #1;
    `CHK(cpu_ctl.cpu_clk_en, 1'b1)
  endtask

  task automatic wake(input logic [3:0] v, input logic b, input logic e, input logic vec);
    int n;
    int exp_n;
    @(posedge ref_clk) stop_req <= 1'b1;
    boost <= b;
    ext_sel <= e;
    ser_a <= b;
    csi_ext <= !b;
    ls_run <= !e;
    view_in <= irq_view_t'(v);
    @(posedge ref_clk) stop_req <= 1'b0;
    #1;
    `CHK(in_stop, 1'b1)
    `CHK(cpu_ctl.cpu_clk_en, 1'b0)
    // Peripheral gating follows the STOP state one edge after entry
    @(posedge ref_clk) irq_fire <= 1'b1;
    #1;
    `CHK(ls_osc, ls_run)
    `CHK(can_run, 1'b1)
    `CHK(md_run, 1'b0)
    `CHK(sa_run, ser_a)
    `CHK(sb_run, ser_a)
    `CHK(csp_run, csi_ext)
    // Software level moves one edge before the edge that leaves STOP; the oscillator follows it once settling starts
    @(posedge ref_clk) irq_fire <= 1'b0;
    ls_run <= e;
    @(posedge ref_clk);
    n = 0;
    do begin
      @(posedge ref_clk) #1;
      n++;
    end while (!(cpu_ctl.vector_take || cpu_ctl.resume_next) && n < 1000);
    exp_n = SETTLE + (b ? (e ? BOOST_EXT_CYC : BOOST_CYC) : 0) +
            (vec ? WAIT_VEC_CYC : WAIT_NOVEC_CYC);
    `CHK(n, exp_n)
    `CHK(cpu_ctl.vector_take, vec)
    `CHK(cpu_ctl.resume_next, !vec)
    `CHK(settle_st, 1'b1)
    `CHK(in_stop, 1'b0)
    `CHK(md_run, 1'b1)
    $display("wake view=%h boost=%0d ext=%0d done", v, b, e);
  endtask

  task automatic rst_src(input int k);
    int i;
    @(posedge ref_clk)
    case (k)
      0: pin_fire <= 1'b1;
      1: wdt <= 1'b1;
      2: power_on_clear <= 1'b1;
      default: lvd <= 1'b1;
    endcase
    @(posedge ref_clk) pin_fire <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk_rst();
    `CHK(wdt_rst, 1'b1)
    if (k == 3)
      `CHK(lvd_blk, 1'b1)
    @(posedge ref_clk) wdt <= 1'b0;
    power_on_clear <= 1'b0;
    lvd <= 1'b0;
    for (i = 0; i < 1300 && reset_pin_n !== 1'b1; i++)
      @(posedge ref_clk) #1;
    boot();
    $display("reset source %0d done", k);
  endtask

  task automatic held();
    // Masked request while stopped: stays asleep until the pin reset
    @(posedge ref_clk) stop_req <= 1'b1;
    view_in <= irq_view_t'(4'b1011);
    @(posedge ref_clk) stop_req <= 1'b0;
    irq_fire <= 1'b1;
    @(posedge ref_clk) irq_fire <= 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    `CHK(in_stop, 1'b1)
    `CHK(cpu_ctl.cpu_clk_en, 1'b0)
    rst_src(0);
    $display("masked hold done");
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1;
    chk_rst();
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    boot();
    // Pin-clocked selections stay fixed while stopped
    wake(4'b0000, 1'b0, 1'b0, 1'b0);
    wake(4'b0011, 1'b0, 1'b0, 1'b1);
    wake(4'b0101, 1'b0, 1'b0, 1'b0);
    wake(4'b0110, 1'b0, 1'b0, 1'b0);
    wake(4'b0111, 1'b0, 1'b0, 1'b1);
    wake(4'b0010, 1'b1, 1'b0, 1'b1);
    wake(4'b0000, 1'b1, 1'b1, 1'b0);
    held();
    for (int k = 1; k < 4; k++)
      rst_src(k);
    end_sim();
  end
endmodule
`default_nettype wire
